// *** logic/odport_regs.svh ***
/*
 constants for the open-drain output port: register offsets, reset values, field widths.
 assumes inclusion by bare name from the design files.
*/
`ifndef ODPORT_REGS_SVH
`define ODPORT_REGS_SVH
`define PORT_LATCH_IDX 32'h0000000F
`define PORT_LATCH_ADDR (`PORT_LATCH_IDX * 4)
`define PORT_LATCH_RESET 8'hFF
`define STANDBY_CTRL_ADDR 32'h00000100
`define STANDBY_FLOAT_BIT 0
`define STANDBY_CTRL_RESET 1'b0
`define ANALOG_SEL_ADDR 32'h00000104
`define ANALOG_SEL_RESET 8'h00
`define PORT_WIDTH 8
`endif

// *** logic/odport_pkg.sv ***
/*
 types shared by the open-drain output port.
 assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package odport_pkg;
   typedef enum logic [1:0] {
      reg_latch,
      reg_standby,
      reg_analog,
      reg_none
   } reg_sel_type;
endpackage
`default_nettype wire

// *** logic/od_pin_driver.sv ***
/*
 per-pin open-drain driver stage with registered enable and route outputs; the data output is tied low.
 assumes latch, standby and analog selects come from the register block on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
module od_pin_driver #(
   parameter int WIDTH = 8
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic [WIDTH-1:0] latch_i,
   input wire logic [WIDTH-1:0] analog_sel_i,
   input wire logic float_i,
   output logic [WIDTH-1:0] pin_out_o,
   output logic [WIDTH-1:0] pin_oe_o,
   output logic [WIDTH-1:0] analog_route_o
);
   logic [WIDTH-1:0] oe_d;
   logic [WIDTH-1:0] oe_q;
   logic [WIDTH-1:0] route_d;
   logic [WIDTH-1:0] route_q;

   always_comb begin
      // a zero latch bit turns the transistor on, forced off while floating
      oe_d = float_i ? '0 : ~latch_i;
      route_d = analog_sel_i;
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         oe_q <= '0;
         route_q <= '0;
      end else begin
         oe_q <= oe_d;
         route_q <= route_d;
      end
   end

   assign pin_out_o = '0;
   assign pin_oe_o = oe_q;
   assign analog_route_o = route_q;

   pin_drive_a: assert property (@(posedge clk_i) disable iff (reset_i)
      oe_q == 0 || !$past(float_i)) else $error("pin driven while floating");
endmodule
`default_nettype wire

// *** logic/odport_top.sv ***
/*
 eight-bit open-drain output port with apb register access and analog pin sharing.
 assumes an apb master on clk_i; pull-ups, if fitted, sit outside on the pin wire.
*/
// Functional notes
// - write loads all eight latch bits
// - latch zero drives pin low
// - latch one releases pin to high impedance
// - fitted pull-up makes released pin high
// - read returns latch, never pin levels
// - bit n maps to pin n
// - latch at index 0Fh, resets all ones
// - standby with float bit forces pins off
`timescale 1ns/100ps
`default_nettype none
`include "odport_regs.svh"
module odport_top #(
   parameter int WIDTH = `PORT_WIDTH
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic standby_enter_i,
   input wire logic [WIDTH-1:0] port_pin_i,
   output logic [WIDTH-1:0] port_pin_o,
   output logic [WIDTH-1:0] port_pin_oe_o,
   output logic [WIDTH-1:0] analog_route_o
);
   logic [WIDTH-1:0] latch_d;
   logic [WIDTH-1:0] latch_q;
   logic float_en_d;
   logic float_en_q;
   logic [WIDTH-1:0] asel_d;
   logic [WIDTH-1:0] asel_q;
   logic floating_d;
   logic floating_q;
   logic [31:0] rdata_d;
   logic [31:0] rdata_q;
   logic ready_d;
   logic ready_q;
   logic err_d;
   logic err_q;
   odport_pkg::reg_sel_type sel;
   logic unused_pins;

   function automatic odport_pkg::reg_sel_type decode(input logic [31:0] addr);
      if (addr == `PORT_LATCH_ADDR) return odport_pkg::reg_latch;
      if (addr == `STANDBY_CTRL_ADDR) return odport_pkg::reg_standby;
      if (addr == `ANALOG_SEL_ADDR) return odport_pkg::reg_analog;
      return odport_pkg::reg_none;
   endfunction

   // pin levels are deliberately never read back
   assign unused_pins = ^port_pin_i;
   assign sel = decode(paddr);

   always_comb begin
      latch_d = latch_q;
      float_en_d = float_en_q;
      asel_d = asel_q;
      rdata_d = rdata_q;
      err_d = 1'b0;
      // no wait state: answer the cycle after setup, drop after completion
      ready_d = psel && !ready_q;
      // read data and the error flag are staged at setup so they stand with pready
      if (psel && !ready_q) begin
         unique case (sel)
            odport_pkg::reg_latch: begin
               rdata_d = {{(32-WIDTH){1'b0}}, latch_q};
            end
            odport_pkg::reg_standby: begin
               rdata_d = {31'h0, float_en_q};
            end
            odport_pkg::reg_analog: begin
               rdata_d = {{(32-WIDTH){1'b0}}, asel_q};
            end
            odport_pkg::reg_none: begin
               rdata_d = 32'h00000000;
               err_d = 1'b1;
            end
         endcase
      end
      // a write lands only at the edge where the master takes pready; an abandoned setup stores nothing
      if (psel && penable && ready_q && pwrite) begin
         unique case (sel)
            odport_pkg::reg_latch: begin
               latch_d = pwdata[WIDTH-1:0];
            end
            odport_pkg::reg_standby: begin
               float_en_d = pwdata[`STANDBY_FLOAT_BIT];
            end
            odport_pkg::reg_analog: begin
               // selecting a channel never touches the latch
               asel_d = pwdata[WIDTH-1:0];
            end
            odport_pkg::reg_none: begin
               // refused address: nothing is stored
               latch_d = latch_q;
            end
         endcase
      end
      // float is taken up in any standby cycle with the float bit set and held while standby lasts
      floating_d = standby_enter_i ? (floating_q || float_en_q) : 1'b0;
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         latch_q <= `PORT_LATCH_RESET;
         float_en_q <= `STANDBY_CTRL_RESET;
         asel_q <= `ANALOG_SEL_RESET;
         floating_q <= 1'b0;
         rdata_q <= 32'h00000000;
         ready_q <= 1'b0;
         err_q <= 1'b0;
      end else begin
         latch_q <= latch_d;
         float_en_q <= float_en_d;
         asel_q <= asel_d;
         floating_q <= floating_d;
         rdata_q <= rdata_d;
         ready_q <= ready_d;
         err_q <= err_d;
      end
   end

   assign prdata = rdata_q;
   assign pready = ready_q;
   assign pslverr = err_q;

   // pull-ups, when fitted, raise a released pin outside the block
   od_pin_driver #(.WIDTH(WIDTH)) u_drv (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .latch_i(latch_q),
      .analog_sel_i(asel_q),
      .float_i(floating_q),
      .pin_out_o(port_pin_o),
      .pin_oe_o(port_pin_oe_o),
      .analog_route_o(analog_route_o)
   );

   // setup cycles of writes to the latch, the standby control and the analog select
   sequence latch_setup_s;
      psel && !penable && pwrite && paddr == `PORT_LATCH_ADDR && !ready_q;
   endsequence
   sequence standby_setup_s;
      psel && !penable && pwrite && paddr == `STANDBY_CTRL_ADDR && !ready_q;
   endsequence
   sequence analog_setup_s;
      psel && !penable && pwrite && paddr == `ANALOG_SEL_ADDR && !ready_q;
   endsequence
   // access edge at which the master takes pready
   sequence access_done_s;
      psel && penable && ready_q;
   endsequence

   // bus side
   latch_write_a: assert property (@(posedge clk_i) disable iff (reset_i)
      latch_setup_s ##1 access_done_s |=> latch_q == $past(pwdata[WIDTH-1:0]))
      else $error("latch not loaded");
   read_latch_a: assert property (@(posedge clk_i) disable iff (reset_i)
      (psel && !pwrite && paddr == `PORT_LATCH_ADDR && !ready_q) |=>
      prdata == {{(32-WIDTH){1'b0}}, $past(latch_q)})
      else $error("readback not latch");
   read_keep_a: assert property (@(posedge clk_i) disable iff (reset_i)
      (psel && penable && ready_q && !pwrite) |=> $stable(latch_q))
      else $error("read changed latch");
   standby_write_a: assert property (@(posedge clk_i) disable iff (reset_i)
      standby_setup_s ##1 access_done_s |=> float_en_q == $past(pwdata[`STANDBY_FLOAT_BIT]))
      else $error("float bit not loaded");
   ready_pulse_a: assert property (@(posedge clk_i) disable iff (reset_i)
      pready |=> !pready)
      else $error("pready longer than one cycle");
   unmapped_err_a: assert property (@(posedge clk_i) disable iff (reset_i)
      (psel && !ready_q && sel == odport_pkg::reg_none) |=> pready && pslverr)
      else $error("unmapped access not refused");
   unmapped_keep_a: assert property (@(posedge clk_i) disable iff (reset_i)
      (psel && penable && ready_q && pwrite && sel == odport_pkg::reg_none) |=>
      $stable(latch_q) && $stable(asel_q) && $stable(float_en_q))
      else $error("unmapped write stored");

   // pin side
   drive_low_a: assert property (@(posedge clk_i) disable iff (reset_i)
      (!floating_q && !$past(floating_q)) |-> port_pin_oe_o == ~$past(latch_q))
      else $error("oe wrong");
   release_high_a: assert property (@(posedge clk_i) disable iff (reset_i)
      $past(latch_q) == '1 |-> port_pin_oe_o == '0)
      else $error("pin not released");
   out_zero_a: assert property (@(posedge clk_i)
      port_pin_o == '0)
      else $error("pin drives high");
   top_pin_a: assert property (@(posedge clk_i) disable iff (reset_i)
      !$past(floating_q) |-> port_pin_oe_o[WIDTH-1] == !$past(latch_q[WIDTH-1]))
      else $error("top pin not bit seven");
   reset_ones_a: assert property (@(posedge clk_i)
      $past(reset_i) |-> latch_q == `PORT_LATCH_RESET)
      else $error("latch reset wrong");
   reset_off_a: assert property (@(posedge clk_i)
      $past(reset_i) |-> port_pin_oe_o == '0)
      else $error("pin driven after reset");

   // standby floating
   float_off_a: assert property (@(posedge clk_i) disable iff (reset_i)
      floating_q |=> port_pin_oe_o == '0)
      else $error("not floated");
   float_entry_a: assert property (@(posedge clk_i) disable iff (reset_i)
      (standby_enter_i && float_en_q) |=> floating_q)
      else $error("float not entered");
   float_exit_a: assert property (@(posedge clk_i) disable iff (reset_i)
      !standby_enter_i |=> !floating_q)
      else $error("float not left");

   // analog sharing
   analog_keep_a: assert property (@(posedge clk_i) disable iff (reset_i)
      analog_setup_s ##1 access_done_s |=> $stable(latch_q))
      else $error("latch disturbed");
   analog_write_a: assert property (@(posedge clk_i) disable iff (reset_i)
      analog_setup_s ##1 access_done_s |=> asel_q == $past(pwdata[WIDTH-1:0]))
      else $error("analog select not loaded");
   route_follow_a: assert property (@(posedge clk_i) disable iff (reset_i)
      analog_route_o == $past(asel_q))
      else $error("route does not follow select");
endmodule
`default_nettype wire

// *** tb/pin_model.sv ***
/*
 pin wire model: eight open-drain pins, with an optional pull-up.
 assumes oe high means the port pulls the pin to pin_out_i.
*/
`timescale 1ns/100ps
`default_nettype none
module pin_model #(
   parameter int WIDTH = 8
) (
   input wire logic clk_i,
   input wire logic pullup_i,
   input wire logic [WIDTH-1:0] pin_out_i,
   input wire logic [WIDTH-1:0] oe_i,
   output logic [WIDTH-1:0] level_o
);
   logic [WIDTH-1:0] noise_q = '0;
   // an undriven pin without pull-up toggles, so a stale level can never pass for a match
   always_ff @(posedge clk_i) begin
      noise_q <= ~noise_q;
   end
   always_comb begin
      level_o = (oe_i & pin_out_i) | (~oe_i & (pullup_i ? '1 : noise_q));
   end
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
/*
 self-checking bench for the open-drain port: apb tasks and directed tests.
 assumes odport_top with one apb slave and the pin wire model.
*/
`timescale 1ns/100ps
`default_nettype none
`include "odport_regs.svh"
module testbench;
   logic clk_i, reset_i, psel, penable, pwrite, pslverr, pready, stby, pull;
   logic [31:0] paddr, pwdata, prdata, r;
   logic [7:0] pin_o, oe, lvl, route;
   logic e;
   int num_errors = 0;
   int n_compared = 0;
   int cycles = 0;
   odport_top dut_u (.clk_i(clk_i), .reset_i(reset_i), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .standby_enter_i(stby), .port_pin_i(lvl), .port_pin_o(pin_o), .port_pin_oe_o(oe),
      .analog_route_o(route));
   pin_model pins_u (.clk_i(clk_i), .pullup_i(pull), .pin_out_i(pin_o), .oe_i(oe), .level_o(lvl));
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end
   task automatic summarize;
      $display("compared %0d, mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // a hang counts against the run
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 2000) begin
         num_errors++;
         summarize();
      end
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk_i);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
      @(posedge clk_i);
      penable <= 1'b1;
      do @(posedge clk_i); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   initial begin
      reset_i <= 1'b1;
      {psel, penable, pwrite, stby} <= 4'h0;
      paddr <= 32'h00000000;
      pwdata <= 32'h00000000;
      pull <= 1'b1;
      repeat (2) @(posedge clk_i);
      reset_i <= 1'b0;
      xfer(1'b0, `PORT_LATCH_ADDR, 32'h0);
      check(r, 32'h000000FF);
      check({24'h0, oe}, 32'h0);
      check({24'h0, route}, 32'h0);
      $display("reset test done");
      xfer(1'b1, `PORT_LATCH_ADDR, 32'hFFFFFF5A);
      repeat (3) @(posedge clk_i);
      check({24'h0, oe}, 32'h000000A5);
      check({24'h0, lvl}, 32'h0000005A);
      pull <= 1'b0;
      xfer(1'b0, `PORT_LATCH_ADDR, 32'h0);
      check(r, 32'h0000005A);
      check({24'h0, lvl & oe}, 32'h0);
      $display("latch test done");
      xfer(1'b1, `STANDBY_CTRL_ADDR, 32'h1);
      xfer(1'b0, `STANDBY_CTRL_ADDR, 32'h0);
      check(r, 32'h00000001);
      stby <= 1'b1;
      repeat (3) @(posedge clk_i);
      check({24'h0, oe}, 32'h0);
      stby <= 1'b0;
      repeat (3) @(posedge clk_i);
      check({24'h0, oe}, 32'h000000A5);
      $display("standby test done");
      xfer(1'b1, `PORT_LATCH_ADDR, 32'hF5);
      xfer(1'b1, `ANALOG_SEL_ADDR, 32'hF0);
      xfer(1'b0, `PORT_LATCH_ADDR, 32'h0);
      check(r, 32'h000000F5);
      check({24'h0, route}, 32'h000000F0);
      $display("analog test done");
      // a second reset in mid-run must bring the latch back to all ones
      reset_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      reset_i <= 1'b0;
      xfer(1'b0, `PORT_LATCH_ADDR, 32'h0);
      check(r, 32'h000000FF);
      check({24'h0, route}, 32'h0);
      $display("second reset test done");
      xfer(1'b1, 32'h00000200, 32'h0);
      check({r[30:0], e}, 32'h1);
      xfer(1'b0, `PORT_LATCH_ADDR, 32'h0);
      check(r, 32'h000000FF);
      $display("unmapped test done");
      summarize();
   end
endmodule
`default_nettype wire
